// File: dv/hri_host_bfm.sv
// Host processor model: whole-word reads and writes on the host port.
// Assumes a free-running clock; requests start at a falling edge.
`timescale 1ns/100ps
`default_nettype none

module hri_host_bfm (
    // Clock
    input  wire logic        clock,
    // Host access
    output logic      [7:0]  hostAddr,
    output logic             hostRd,
    output logic             hostWr,
    output logic      [31:0] hostWdata,
    input  wire logic [31:0] hostRdata,
    input  wire logic        hostRvalid
);
    int misses = 0;

    initial begin
        hostAddr  = 8'h00;
        hostRd    = 1'b0;
        hostWr    = 1'b0;
        hostWdata = 32'h00000000;
    end

    // Callers never aim at reserved offsets and send reserved bits as zero
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge clock);
        hostAddr  = a;
        hostWdata = d;
        hostWr    = 1'b1;
        @(negedge clock);
        hostWr    = 1'b0;
        hostWdata = ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(negedge clock);
        hostAddr = a;
        hostRd   = 1'b1;
        @(negedge clock);
        hostRd = 1'b0;
        if (hostRvalid !== 1'b1) misses++;
        d = hostRdata;
    endtask
endmodule // hri_host_bfm
`default_nettype wire

// File: dv/hri_host_port_asserts.sv
// Port-level checks of the host access layer.
// Assumes binding to hri_host_port; sees only its ports.
`timescale 1ns/100ps
`default_nettype none
`include "hri_map.svh"

module hri_host_port_asserts #(
    parameter logic [31:0] CHIP_ID = 32'hA5A50001
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Host access
    input  wire logic [7:0]  hostAddr,
    input  wire logic        hostRd,
    input  wire logic        hostWr,
    input  wire logic [31:0] hostWdata,
    input  wire logic [31:0] hostRdata,
    input  wire logic        hostRvalid,
    // Transmit drain and soft reset
    input  wire logic [31:0] txWord,
    input  wire logic        txWordValid,
    input  wire logic        txWordReady,
    input  wire logic        softResetPulse
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    a_read_answer: assert property (hostRd |=> hostRvalid)
        else $error("read got no answer");
    a_answer_cause: assert property (hostRvalid |-> $past(hostRd))
        else $error("answer without read");
    a_byte_test: assert property (hostRd && hostAddr == `HRI_BYTE_TEST
        |=> hostRdata == `HRI_BYTE_TEST_VAL)
        else $error("byte test value wrong");
    a_id_fixed: assert property (hostRd && hostAddr == `HRI_ID
        |=> hostRdata == CHIP_ID)
        else $error("id value wrong");
    a_txd_reads_zero: assert property (hostRd && hostAddr[7:5] == 3'b001
        |=> hostRdata == 32'h00000000)
        else $error("tx data window read not zero");
    a_pulse_single: assert property (softResetPulse |=> !softResetPulse)
        else $error("soft reset pulse too long");
    a_pulse_cause: assert property (softResetPulse |->
        $past(hostWr && hostAddr == `HRI_HWCFG && hostWdata[0]))
        else $error("soft reset pulse without write");
    a_tx_word_hold: assert property (
        txWordValid && !txWordReady && !softResetPulse
        |=> txWordValid && $stable(txWord))
        else $error("tx word dropped while stalled");

    c_peek: cover property (hostRd && hostAddr == `HRI_RXS_PEEK);
    c_soft: cover property (softResetPulse);
    c_stall: cover property (txWordValid && !txWordReady);
endmodule // hri_host_port_asserts

bind hri_host_port hri_host_port_asserts #(.CHIP_ID(CHIP_ID)) u_asserts (
    .clock, .rst_n, .hostAddr, .hostRd, .hostWr, .hostWdata, .hostRdata,
    .hostRvalid, .txWord, .txWordValid, .txWordReady, .softResetPulse
);
`default_nettype wire

// File: dv/tb_top.sv
// Self-checking bench for the host access layer.
// Assumes hri_host_bfm as host and a random-stall transmit sink.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
    localparam logic [31:0] ID = 32'h3C3C0002; // Arbitrary value
    logic        clock = 1'b0;
    logic        rst_n = 1'b0;
    logic        bus16Pin = 1'b0;
    logic [2:0]  pushSel = 3'b000;
    logic [31:0] pushData = 32'h00000000;
    logic        txWordReady = 1'b0;
    logic        linkUp = 1'b0;
    logic        linkFault = 1'b0;
    logic [7:0]  hostAddr;
    logic        hostRd, hostWr, hostRvalid, txWordValid, softResetPulse;
    logic        rxStatFull, rxDataFull, txStatFull;
    logic [31:0] hostWdata, hostRdata, txWord;
    logic [31:0] v[$];
    logic [31:0] txq[$];
    int          n_errors = 0;
    int          check_count = 0;

    always #5 clock = ~clock;

    hri_host_port #(.CHIP_ID(ID)) DUT (
        .clock, .rst_n, .bus16Pin, .hostAddr, .hostRd, .hostWr, .hostWdata,
        .hostRdata, .hostRvalid, .rxStatPush(pushSel[0]),
        .rxStatData(pushData), .rxStatFull, .rxDataPush(pushSel[1]),
        .rxDataWord(pushData), .rxDataFull, .txStatPush(pushSel[2]),
        .txStatData(pushData), .txStatFull, .txWord, .txWordValid,
        .txWordReady, .linkUp, .linkFault, .softResetPulse
    );
    hri_host_bfm host (
        .clock, .hostAddr, .hostRd, .hostWr, .hostWdata, .hostRdata,
        .hostRvalid
    );

    // Transmit sink with random stalls
    always @(negedge clock) txWordReady <= 1'($urandom_range(0, 1));
    always @(posedge clock) begin
        if (rst_n && txWordValid && txWordReady) txq.push_back(txWord);
    end

    function automatic logic [31:0] info(int s, int d);
        return {11'h000, 5'(s), 9'h000, 7'(d)};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    task automatic rc(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        host.rd(a, d);
        chk(d, e);
    endtask

    // Fills n random words into FIFO w and keeps them in v
    task automatic fill(input int w, input int n);
        v = {};
        repeat (n) begin
            v.push_back($urandom);
            @(negedge clock);
            pushSel  = 3'(1 << w);
            pushData = v[$];
            @(negedge clock);
            pushSel  = 3'b000;
        end
    endtask

    task automatic stop_test;
        n_errors += host.misses;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    initial begin
        void'($urandom(32'hB02B));
        repeat (16) @(negedge clock);
        rst_n = 1'b1;
        // Defaults, read-only and write-only places
        rc(8'h64, 32'h87654321);
        rc(8'h58, 32'h0);
        rc(8'hA0, 32'h0);
        host.wr(8'h64, $urandom);
        rc(8'h64, 32'h87654321);
        host.wr(8'h50, $urandom);
        rc(8'h50, ID);
        rc(8'h3C, 32'h0);
        rc(8'(8'h20 + 4 * $urandom_range(0, 6)), 32'h0);
        $display("test access done");
        // Receive status: peek, pop, empty pop, write-one-to-clear
        fill(0, 3);
        rc(8'h7C, info(3, 0));
        rc(8'h44, v[0]);
        rc(8'h44, v[0]);
        for (int i = 0; i < 3; i++) rc(8'h40, v[i]);
        host.rd(8'h40, pushData);
        rc(8'h7C, info(0, 0));
        fill(0, 1);
        rc(8'h40, v[0]);
        rc(8'h58, 32'h1);
        host.wr(8'h58, 32'h0);
        rc(8'h58, 32'h1);
        host.wr(8'h58, 32'h1);
        rc(8'h58, 32'h0);
        $display("test status done");
        // Receive data over every alias in both bus modes
        host.wr(8'h00, $urandom);
        rc(8'h7C, info(0, 0));
        fill(1, 8);
        for (int i = 0; i < 8; i++) rc(8'(4 * i), v[i]);
        bus16Pin = 1'b1;
        fill(1, 16);
        for (int i = 0; i < 16; i++) rc(8'(2 * i), v[i]);
        bus16Pin = 1'b0;
        repeat (5) @(negedge clock);
        $display("test rx data done");
        // Transmit status and data
        fill(2, 2);
        rc(8'h4C, v[0]);
        rc(8'h48, v[0]);
        rc(8'h48, v[1]);
        v = {};
        for (int i = 0; i < 8; i++) begin
            v.push_back($urandom);
            host.wr(8'(8'h20 + 4 * i), v[i]);
        end
        for (int i = 0; i < 200 && txq.size() < 8; i++) @(negedge clock);
        if (txq.size() != 8) begin
            n_errors++;
            stop_test();
        end
        for (int i = 0; i < 8; i++) chk(txq[i], v[i]);
        $display("test tx done");
        // Latching link bits
        linkUp = 1'b1;
        host.rd(8'h84, pushData);
        rc(8'h84, 32'h1);
        @(negedge clock);
        linkUp    = 1'b0;
        linkFault = 1'b1;
        @(negedge clock);
        linkUp    = 1'b1;
        linkFault = 1'b0;
        rc(8'h84, 32'h2);
        rc(8'h84, 32'h1);
        $display("test latch done");
        // Size limit and soft reset
        host.wr(8'h74, 32'h00010102);
        rc(8'h74, 32'h00010102);
        fill(0, 1);
        fill(1, 2);
        fill(2, 16);
        chk({rxStatFull, rxDataFull, txStatFull}, 3'h7);
        rc(8'hA0, 32'h1);
        rc(8'hA0, 32'h0);
        host.wr(8'h74, 32'h00000003);
        repeat (3) @(negedge clock);
        rc(8'h74, 32'h00000002);
        rc(8'h7C, info(0, 0));
        chk({rxStatFull, rxDataFull, txStatFull}, 3'h0);
        $display("test soft reset done");
        stop_test();
    end
endmodule // tb_top
`default_nettype wire

// File: src/hri_bit_cell.sv
// One register bit with a selectable host access behaviour.
// Assumes one-cycle read and write strobes for its register.
`timescale 1ns/100ps
`default_nettype none

module hri_bit_cell
    import hri_pkg::*;
#(
    parameter hri_kind_e KIND   = KIND_RW,
    parameter bit        RESET  = 1'b0,
    parameter bit        IMMUNE = 1'b0
) (
    // Clock and resets
    input  wire logic clock,
    input  wire logic rst_n,
    input  wire logic softRst,
    // Host access
    input  wire logic wrEn,
    input  wire logic wrBit,
    input  wire logic rdEn,
    // Hardware side
    input  wire logic hwIn,
    output logic      q
);

    logic q_reg;
    assign q = q_reg;

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            q_reg <= RESET;
        end else if (softRst && !IMMUNE) begin
            q_reg <= RESET;
        end else begin
            unique case (KIND)
                KIND_RW:  if (wrEn) q_reg <= wrBit;
                KIND_RO:  q_reg <= hwIn;
                KIND_W1C: begin
                    if (hwIn) q_reg <= 1'b1;
                    else if (wrEn && wrBit) q_reg <= 1'b0;
                end
                KIND_RC: begin
                    if (hwIn) q_reg <= 1'b1;
                    else if (rdEn) q_reg <= 1'b0;
                end
                KIND_LL: begin
                    if (rdEn) q_reg <= hwIn;
                    else if (!hwIn) q_reg <= 1'b0;
                end
                KIND_LH: begin
                    if (rdEn) q_reg <= hwIn;
                    else if (hwIn) q_reg <= 1'b1;
                end
                KIND_SC:  q_reg <= wrEn && wrBit;
            endcase
        end
    end

endmodule // hri_bit_cell

`default_nettype wire

// File: src/hri_fifo.sv
// Synchronous FIFO with a run-time size limit and registered flags.
// Assumes DEPTH is a power of two; push when full and pop when empty drop.
`timescale 1ns/100ps
`default_nettype none

module hri_fifo
    import hri_pkg::*;
#(
    parameter int WIDTH = 32,
    parameter int DEPTH = 16,
    localparam int CW   = $clog2(DEPTH + 1),
    localparam int AW   = $clog2(DEPTH)
) (
    // Clock and reset
    input  wire logic             clock,
    input  wire logic             rst_n,
    input  wire logic             flush,
    // Size control
    input  wire logic [CW-1:0]    limit,
    // Fill side
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] pushData,
    // Drain side
    input  wire logic             pop,
    output logic      [WIDTH-1:0] headData,
    // State
    output logic      [CW-1:0]    count,
    output logic                  full,
    output logic                  empty
);

    localparam logic [CW-1:0] DEPTH_C = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [CW-1:0]    count_reg;
    logic             full_reg;
    logic             empty_reg;

    wire logic [CW-1:0] effLimit = (limit == '0 || limit > DEPTH_C) ?
                                   DEPTH_C : limit;
    wire logic          doPush   = push && !full_reg;
    wire logic          doPop    = pop && !empty_reg;
    wire logic [CW-1:0] count_next = flush ? '0 :
        CW'(count_reg + CW'(doPush) - CW'(doPop));

    assign headData = mem[rdPtr_reg];
    assign count    = count_reg;
    assign full     = full_reg;
    assign empty    = empty_reg;

    always_ff @(posedge clock) begin
        if (doPush) mem[wrPtr_reg] <= pushData;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            full_reg  <= 1'b0;
            empty_reg <= 1'b1;
        end else begin
            wrPtr_reg <= flush ? '0 : AW'(wrPtr_reg + AW'(doPush));
            rdPtr_reg <= flush ? '0 : AW'(rdPtr_reg + AW'(doPop));
            count_reg <= count_next;
            full_reg  <= count_next >= effLimit;
            empty_reg <= count_next == '0;
        end
    end

endmodule // hri_fifo

`default_nettype wire

// File: src/hri_host_port.sv
// Host access layer: FIFO ports, register attribute handling, reset values.
// Assumes host strobes are one-cycle pulses synchronous to clock.
//
// Operation
// - Host writes to read-only registers are ignored.
// - Reads of write-only locations return zero.
// - Write-one clears a bit; writing zero leaves it.
// - Clear-on-read bits clear when their register is read.
// - Latching bits hold their state until read, then reload the current input level.
// - Soft-reset-immune bits keep their value across a software reset.
// - Hard reset loads all internal registers except FIFO storage with their defaults.
// - Four host FIFOs; data and receive status sizes are configurable.
// - Receive FIFOs are read-only; host writes never enter them.
// - Receive status pop read returns and removes the oldest entry.
// - Receive status peek read returns the oldest entry, keeps it.
// - Every receive data read returns and removes the oldest word.
// - Receive data port aliased over 8 or 16 locations by bus mode.
// - Transmit status pop read returns and removes the oldest entry.
// - Transmit status peek read returns the oldest entry, keeps it.
// - Transmit data port is write-only and not readable.
// - Transmit data writes enqueue alike at 8 or 16 aliased locations.
// - Control registers start at 50h; byte test at 64h is fixed.
`timescale 1ns/100ps
`default_nettype none
`include "hri_map.svh"

module hri_host_port
    import hri_pkg::*;
#(
    // Identification value; arbitrary
    parameter logic [31:0] CHIP_ID = 32'hA5A50001
) (
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    // Bus mode pin, high for 16-bit mode
    input  wire logic        bus16Pin,
    // Host access
    input  wire logic [7:0]  hostAddr,
    input  wire logic        hostRd,
    input  wire logic        hostWr,
    input  wire logic [31:0] hostWdata,
    output logic      [31:0] hostRdata,
    output logic             hostRvalid,
    // Receive status fill side
    input  wire logic        rxStatPush,
    input  wire logic [31:0] rxStatData,
    output logic             rxStatFull,
    // Receive data fill side
    input  wire logic        rxDataPush,
    input  wire logic [31:0] rxDataWord,
    output logic             rxDataFull,
    // Transmit status fill side
    input  wire logic        txStatPush,
    input  wire logic [31:0] txStatData,
    output logic             txStatFull,
    // Transmit data drain side
    output logic      [31:0] txWord,
    output logic             txWordValid,
    input  wire logic        txWordReady,
    // Link levels
    input  wire logic        linkUp,
    input  wire logic        linkFault,
    // Software reset pulse to the rest of the chip
    output logic             softResetPulse
);

    //------------------------------------------------------------------
    // Bus mode pin synchroniser
    //------------------------------------------------------------------
    logic modeS1_reg;
    logic modeS2_reg;
    logic modeS3_reg;
    logic bus16_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            modeS1_reg <= 1'b0;
            modeS2_reg <= 1'b0;
            modeS3_reg <= 1'b0;
            bus16_reg  <= 1'b0;
        end else begin
            modeS1_reg <= bus16Pin;
            modeS2_reg <= modeS1_reg;
            modeS3_reg <= modeS2_reg;
            if (modeS2_reg == modeS3_reg) bus16_reg <= modeS3_reg;
        end
    end

    //------------------------------------------------------------------
    // Address decode
    //------------------------------------------------------------------
    wire logic [7:0] win32   = `HRI_ALIAS_32 * `HRI_LOC_32;
    wire logic [7:0] win16   = `HRI_ALIAS_16 * `HRI_LOC_16;
    wire logic [7:0] winSize = bus16_reg ? win16 : win32;
    wire logic [7:0] rxdOff  = hostAddr - `HRI_RXD_BASE;
    wire logic [7:0] txdOff  = hostAddr - `HRI_TXD_BASE;
    wire logic [7:0] dwAddr  = {hostAddr[7:2], 2'b00};
    wire logic inRxd     = rxdOff < winSize;
    wire logic inTxd     = txdOff < winSize;
    wire logic selRxsPop = dwAddr == `HRI_RXS_POP;
    wire logic selRxsPk  = dwAddr == `HRI_RXS_PEEK;
    wire logic selTxsPop = dwAddr == `HRI_TXS_POP;
    wire logic selTxsPk  = dwAddr == `HRI_TXS_PEEK;
    wire logic selId     = dwAddr == `HRI_ID;
    wire logic selEvt    = dwAddr == `HRI_EVT;
    wire logic selBtest  = dwAddr == `HRI_BYTE_TEST;
    wire logic selHwcfg  = dwAddr == `HRI_HWCFG;
    wire logic selRxinf  = dwAddr == `HRI_RXINF;
    wire logic selTxinf  = dwAddr == `HRI_TXINF;
    wire logic selLink   = dwAddr == `HRI_LINK;
    wire logic selDrop   = dwAddr == `HRI_DROP;
    wire logic rxsPopRd = hostRd && selRxsPop;
    wire logic txsPopRd = hostRd && selTxsPop;
    wire logic rxdRd    = hostRd && inRxd;
    wire logic txdWr    = hostWr && inTxd;
    wire logic evtWr    = hostWr && selEvt;
    wire logic hwcfgWr  = hostWr && selHwcfg;
    wire logic linkRd   = hostRd && selLink;
    wire logic dropRd   = hostRd && selDrop;

    //------------------------------------------------------------------
    // Configuration and software reset
    //------------------------------------------------------------------
    logic       softRst;
    logic       keepBit;
    logic [4:0] rxsLim_reg;
    logic [6:0] rxdLim_reg;
    logic [6:0] txdLim_reg;
    assign softResetPulse = softRst;
    hri_bit_cell #(.KIND(KIND_SC), .RESET(1'b0), .IMMUNE(1'b1)) u_srst (
        .clock   (clock),
        .rst_n   (rst_n),
        .softRst (softRst),
        .wrEn    (hwcfgWr),
        .wrBit   (hostWdata[`HRI_HWCFG_SRST]),
        .rdEn    (1'b0),
        .hwIn    (1'b0),
        .q       (softRst)
    );

    hri_bit_cell #(.KIND(KIND_RW), .RESET(1'b0), .IMMUNE(1'b1)) u_keep (
        .clock   (clock),
        .rst_n   (rst_n),
        .softRst (softRst),
        .wrEn    (hwcfgWr),
        .wrBit   (hostWdata[`HRI_HWCFG_KEEP]),
        .rdEn    (1'b0),
        .hwIn    (1'b0),
        .q       (keepBit)
    );

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rxsLim_reg <= `HRI_RXS_LIM_RST;
            rxdLim_reg <= `HRI_DAT_LIM_RST;
            txdLim_reg <= `HRI_DAT_LIM_RST;
        end else if (softRst) begin
            rxsLim_reg <= `HRI_RXS_LIM_RST;
            rxdLim_reg <= `HRI_DAT_LIM_RST;
            txdLim_reg <= `HRI_DAT_LIM_RST;
        end else if (hwcfgWr) begin
            rxsLim_reg <= hostWdata[`HRI_HWCFG_RXS_LSB +: 5];
            rxdLim_reg <= hostWdata[`HRI_HWCFG_RXD_LSB +: 7];
            txdLim_reg <= hostWdata[`HRI_HWCFG_TXD_LSB +: 7];
        end
    end

    //------------------------------------------------------------------
    // FIFOs
    //------------------------------------------------------------------
    logic [31:0] rxsHead;
    logic [31:0] rxdHead;
    logic [31:0] txsHead;
    logic [31:0] txdHead;
    logic [4:0]  rxsCount;
    logic [6:0]  rxdCount;
    logic [4:0]  txsCount;
    logic [6:0]  txdCount;
    logic        txdFull;
    logic        txdEmpty;
    logic        txWordValid_reg;
    logic [31:0] txWord_reg;
    wire logic loadTx = !txdEmpty && (!txWordValid_reg || txWordReady);
    // Host accesses never push the receive FIFOs
    hri_fifo #(.WIDTH(32), .DEPTH(`HRI_STS_DEPTH)) u_rxs (
        .clock    (clock),
        .rst_n    (rst_n),
        .flush    (softRst),
        .limit    (rxsLim_reg),
        .push     (rxStatPush),
        .pushData (rxStatData),
        .pop      (rxsPopRd),
        .headData (rxsHead),
        .count    (rxsCount),
        .full     (rxStatFull),
        .empty    ()
    );

    hri_fifo #(.WIDTH(32), .DEPTH(`HRI_DAT_DEPTH)) u_rxd (
        .clock    (clock),
        .rst_n    (rst_n),
        .flush    (softRst),
        .limit    (rxdLim_reg),
        .push     (rxDataPush),
        .pushData (rxDataWord),
        .pop      (rxdRd),
        .headData (rxdHead),
        .count    (rxdCount),
        .full     (rxDataFull),
        .empty    ()
    );

    hri_fifo #(.WIDTH(32), .DEPTH(`HRI_STS_DEPTH)) u_txs (
        .clock    (clock),
        .rst_n    (rst_n),
        .flush    (softRst),
        .limit    (5'h00),
        .push     (txStatPush),
        .pushData (txStatData),
        .pop      (txsPopRd),
        .headData (txsHead),
        .count    (txsCount),
        .full     (txStatFull),
        .empty    ()
    );

    hri_fifo #(.WIDTH(32), .DEPTH(`HRI_DAT_DEPTH)) u_txd (
        .clock    (clock),
        .rst_n    (rst_n),
        .flush    (softRst),
        .limit    (txdLim_reg),
        .push     (txdWr),
        .pushData (hostWdata),
        .pop      (loadTx),
        .headData (txdHead),
        .count    (txdCount),
        .full     (txdFull),
        .empty    (txdEmpty)
    );

    // Output stage so the drain side sees flops only
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            txWordValid_reg <= 1'b0;
            txWord_reg      <= 32'h00000000;
        end else if (softRst) begin
            txWordValid_reg <= 1'b0;
        end else if (loadTx) begin
            txWordValid_reg <= 1'b1;
            txWord_reg      <= txdHead;
        end else if (txWordReady) begin
            txWordValid_reg <= 1'b0;
        end
    end

    assign txWordValid = txWordValid_reg;
    assign txWord      = txWord_reg;

    //------------------------------------------------------------------
    // Event status, link latches, drop counter
    //------------------------------------------------------------------
    logic [3:0] evtQ;
    logic       linkUpQ;
    logic       faultQ;
    logic [31:0] drop_reg;

    wire logic rxOvf = rxDataPush && rxDataFull;
    wire logic [3:0] evtSet = {txdWr && txdFull, rxOvf,
                               txStatPush, rxStatPush};
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_evt
            hri_bit_cell #(.KIND(KIND_W1C), .RESET(1'b0), .IMMUNE(1'b0))
            u_evt (
                .clock   (clock),
                .rst_n   (rst_n),
                .softRst (softRst),
                .wrEn    (evtWr),
                .wrBit   (hostWdata[gi]),
                .rdEn    (1'b0),
                .hwIn    (evtSet[gi]),
                .q       (evtQ[gi])
            );
        end
    endgenerate

    hri_bit_cell #(.KIND(KIND_LL), .RESET(1'b0), .IMMUNE(1'b0)) u_linkup (
        .clock   (clock),
        .rst_n   (rst_n),
        .softRst (softRst),
        .wrEn    (1'b0),
        .wrBit   (1'b0),
        .rdEn    (linkRd),
        .hwIn    (linkUp),
        .q       (linkUpQ)
    );

    hri_bit_cell #(.KIND(KIND_LH), .RESET(1'b0), .IMMUNE(1'b0)) u_fault (
        .clock   (clock),
        .rst_n   (rst_n),
        .softRst (softRst),
        .wrEn    (1'b0),
        .wrBit   (1'b0),
        .rdEn    (linkRd),
        .hwIn    (linkFault),
        .q       (faultQ)
    );

    // Counter clears on read; a drop in the same cycle still counts
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            drop_reg <= `HRI_DROP_RST;
        end else if (softRst) begin
            drop_reg <= `HRI_DROP_RST;
        end else if (dropRd) begin
            drop_reg <= {31'h00000000, rxOvf};
        end else if (rxOvf && drop_reg != 32'hFFFFFFFF) begin
            drop_reg <= drop_reg + 32'h00000001;
        end
    end

    //------------------------------------------------------------------
    // Read data select
    //------------------------------------------------------------------
    wire logic [31:0] hwcfgRd = {1'b0, txdLim_reg, 1'b0, rxdLim_reg, 3'h0,
                                 rxsLim_reg, 6'h00, keepBit, softRst};
    wire logic [31:0] rxinfRd = {11'h000, rxsCount, 9'h000, rxdCount};
    wire logic [31:0] txinfRd = {11'h000, txsCount, 9'h000, txdCount};

    // Transmit data window and reserved space read as zero
    wire logic [31:0] readMux =
        inRxd                  ? rxdHead :
        (selRxsPop | selRxsPk) ? rxsHead :
        (selTxsPop | selTxsPk) ? txsHead :
        inTxd                  ? 32'h00000000 :
        selId                  ? CHIP_ID :
        selEvt                 ? {28'h0000000, evtQ} :
        selBtest               ? `HRI_BYTE_TEST_VAL :
        selHwcfg               ? hwcfgRd :
        selRxinf               ? rxinfRd :
        selTxinf               ? txinfRd :
        selLink                ? {30'h00000000, faultQ, linkUpQ} :
        selDrop                ? drop_reg :
                                 32'h00000000;

    logic [31:0] hostRdata_reg;
    logic        hostRvalid_reg;
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            hostRdata_reg  <= 32'h00000000;
            hostRvalid_reg <= 1'b0;
        end else begin
            hostRvalid_reg <= hostRd;
            if (hostRd) hostRdata_reg <= readMux;
        end
    end
    assign hostRdata  = hostRdata_reg;
    assign hostRvalid = hostRvalid_reg;

endmodule // hri_host_port

`default_nettype wire

// File: src/hri_map.svh
// Offsets, field positions, reset values and sizes of the host access layer.
// Included by hri_host_port and its assertion module; holds definitions only.
`ifndef HRI_MAP_SVH
`define HRI_MAP_SVH

// FIFO port windows and single-word ports
`define HRI_RXD_BASE      8'h00
`define HRI_TXD_BASE      8'h20
`define HRI_RXS_POP       8'h40
`define HRI_RXS_PEEK      8'h44
`define HRI_TXS_POP       8'h48
`define HRI_TXS_PEEK      8'h4C

// Alias counts and location sizes per bus mode
`define HRI_ALIAS_32      8'h08
`define HRI_LOC_32        8'h04
`define HRI_ALIAS_16      8'h10
`define HRI_LOC_16        8'h02

// Control and status registers
`define HRI_ID            8'h50
`define HRI_EVT           8'h58
`define HRI_BYTE_TEST     8'h64
`define HRI_HWCFG         8'h74
`define HRI_RXINF         8'h7C
`define HRI_TXINF         8'h80
`define HRI_LINK          8'h84
`define HRI_DROP          8'hA0

// Fixed values
`define HRI_BYTE_TEST_VAL 32'h87654321
`define HRI_DROP_RST      32'h00000000

// Hardware configuration fields
`define HRI_HWCFG_SRST    0
`define HRI_HWCFG_KEEP    1
`define HRI_HWCFG_RXS_LSB 8
`define HRI_HWCFG_RXD_LSB 16
`define HRI_HWCFG_TXD_LSB 24
`define HRI_RXS_LIM_RST   5'h00
`define HRI_DAT_LIM_RST   7'h00

// Event status bits
`define HRI_EVT_RXS       0
`define HRI_EVT_TXS       1
`define HRI_EVT_RXOVF     2
`define HRI_EVT_TXOVR     3

// FIFO depths
`define HRI_STS_DEPTH     16
`define HRI_DAT_DEPTH     64

`endif

// File: src/hri_pkg.sv
// Types shared by the host access layer.
// Assumes nothing of its surroundings.
package hri_pkg;

    // Host-visible behaviour of one register bit
    typedef enum {
        KIND_RW,
        KIND_RO,
        KIND_W1C,
        KIND_RC,
        KIND_LL,
        KIND_LH,
        KIND_SC
    } hri_kind_e;

endpackage
